// ==== core/sms_top.sv ====
// Serial peripheral master shifter: settings and streams on clk, shifting on link_clk.
//
// Notes on behaviour
// RULE_01 - This block is the bus master and alone drives the serial clock.
// RULE_02 - Polarity sets the level the serial clock rests at between transfers.
// RULE_03 - Phase 0 samples on each bit's first edge, phase 1 on the second.
// RULE_04 - Word width is programmable from one to eight bits; eight always works.
// RULE_05 - Bit order selects most or least significant bit first, both ways.
// RULE_06 - Clock rate follows the half-period divider; zero selects the 1 MHz default. Here dividers of 1 and 2 are raised to 3.
// RULE_07 - Read transfers send the fill byte each word and deliver every received word.
// RULE_08 - Write transfers shift out supplied words in order and deliver nothing back.
// RULE_09 - Duplex transfers use one count: one received word for each sent word.
// RULE_10 - Slave select comes from separate general-purpose pins, not from this block.
// RULE_11 - Disabling stops all shifting and keeps the bus idle until reconfigured.
// RULE_12 - Settings persist until the next configuration load.
// RULE_13 - Words go back to back; clock returns idle and completion pulses at the end.
`timescale 1ns/100ps
module sms_top (
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link reference clock
    input wire logic link_clk,
    // Configuration
    input wire logic cfg_load,
    input wire logic cfg_cpol,
    input wire logic cfg_cpha,
    input wire logic [2:0] cfg_bits,
    input wire logic cfg_lsb_first,
    input wire logic [7:0] cfg_half_div,
    input wire logic [7:0] cfg_fill,
    input wire logic bus_off,
    output logic cfg_active,
    // Transfer command and status
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_mode,
    input wire logic [7:0] cmd_count,
    output logic busy,
    output logic done,
    // Transmit words
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Received words
    output logic rx_valid,
    output logic [7:0] rx_data,
    // Serial pins
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso
);

    // ****************************************************************
    // System side state
    // ****************************************************************
    logic cur_cpol, cur_cpha, cur_lsb;
    logic [2:0] cur_bits;
    logic [7:0] cur_div, cur_fill;
    logic [1:0] mode;
    logic [7:0] count_q, tx_left, tx_hold;
    logic tx_full, tx_req, start_tgl;
    logic ack_s, rxt_s, done_s, ack_seen, rx_seen, done_seen;

    // ****************************************************************
    // Link side state
    // ****************************************************************
    logic link_rst;
    sms_pkg::sms_lstate_t l_st;
    logic l_en_s, l_cpol_s, l_start_s, l_req_s, l_miso_s;
    logic l_start_seen, l_tx_seen, l_ack, l_rx_tgl, l_done_tgl;
    logic l_cpha, l_lsb;
    logic [2:0] l_bits;
    logic [1:0] l_mode;
    logic [7:0] l_div, l_fill, l_left, l_hcnt, l_word, l_rxw, l_rx_word;
    logic [3:0] l_edge;

    // ****************************************************************
    // Crossings
    // ****************************************************************
    sms_rst_sync u_link_rst (.clk(link_clk), .rst_in(sys_rst), .rst_out(link_rst));
    sms_sync u_en (.clk(link_clk), .rst(link_rst), .d(cfg_active), .q(l_en_s));
    sms_sync u_cpol (.clk(link_clk), .rst(link_rst), .d(cur_cpol), .q(l_cpol_s));
    sms_sync u_start (.clk(link_clk), .rst(link_rst), .d(start_tgl), .q(l_start_s));
    sms_sync u_req (.clk(link_clk), .rst(link_rst), .d(tx_req), .q(l_req_s));
    sms_sync u_miso (.clk(link_clk), .rst(link_rst), .d(spi_miso), .q(l_miso_s));
    sms_sync u_ack (.clk(clk), .rst(sys_rst), .d(l_ack), .q(ack_s));
    sms_sync u_rxt (.clk(clk), .rst(sys_rst), .d(l_rx_tgl), .q(rxt_s));
    sms_sync u_done (.clk(clk), .rst(sys_rst), .d(l_done_tgl), .q(done_s));

    // ****************************************************************
    // System side decode
    // ****************************************************************
    wire cmd_go = cmd_valid && !busy && cfg_active && !bus_off &&
                  cmd_count != 8'h00 && cmd_mode != sms_pkg::MODE_NONE;
    wire ack_ev = ack_s != ack_seen;
    wire rx_ev = rxt_s != rx_seen;
    wire done_ev = done_s != done_seen;
    wire tx_take = tx_valid && tx_ready;
    wire cfg_take = cfg_load && !busy && !bus_off;
    // A short divider would let the two-stage sync on the data-in line eat the bit.
    wire [7:0] eff_div = (cfg_half_div == 8'h00) ? sms_pkg::DEFAULT_HALF_DIV :    // [RULE_06]
                         (cfg_half_div < sms_pkg::MIN_HALF_DIV) ? sms_pkg::MIN_HALF_DIV :
                         cfg_half_div;
    wire next_busy = bus_off ? 1'b0 : cmd_go ? 1'b1 : done_ev ? 1'b0 : busy;
    wire [1:0] next_mode = cmd_go ? cmd_mode : mode;
    wire [7:0] next_left = bus_off ? 8'h00 :
                           cmd_go ? ((cmd_mode == sms_pkg::MODE_READ) ? 8'h00 : cmd_count) :
                           tx_take ? tx_left - 8'h01 : tx_left;
    wire next_full = tx_take ? 1'b1 : ack_ev ? 1'b0 : tx_full;
    wire next_ready = next_busy && next_mode != sms_pkg::MODE_READ &&    // [RULE_07]
                      next_left != 8'h00 && !next_full;
    wire rx_keep = rx_ev && busy && mode != sms_pkg::MODE_WRITE;    // [RULE_08]

    // ****************************************************************
    // System side registers
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_cpol <= sms_pkg::RST_CPOL;
            cur_cpha <= sms_pkg::RST_CPHA;
            cur_bits <= sms_pkg::RST_BITS;
            cur_lsb <= sms_pkg::RST_LSB_FIRST;
            cur_div <= sms_pkg::DEFAULT_HALF_DIV;
            cur_fill <= sms_pkg::RST_FILL;
        end else if (cfg_take) begin    // [RULE_12]
            cur_cpol <= cfg_cpol;
            cur_cpha <= cfg_cpha;
            cur_bits <= cfg_bits;
            cur_lsb <= cfg_lsb_first;
            cur_div <= eff_div;
            cur_fill <= cfg_fill;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_active <= 1'b0;
        end else if (bus_off) begin
            cfg_active <= 1'b0;    // [RULE_11]
        end else if (cfg_take) begin
            cfg_active <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            mode <= sms_pkg::MODE_NONE;
            tx_left <= 8'h00;
            tx_full <= 1'b0;
            tx_ready <= 1'b0;
        end else begin
            busy <= next_busy;
            mode <= next_mode;
            tx_left <= next_left;    // [RULE_09]
            tx_full <= next_full;
            tx_ready <= next_ready;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= 8'h00;
            start_tgl <= 1'b0;
        end else if (cmd_go) begin
            count_q <= cmd_count;
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_hold <= 8'h00;
            tx_req <= 1'b0;
        end else if (tx_take) begin
            tx_hold <= tx_data;
            tx_req <= ~tx_req;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_seen <= 1'b0;
            rx_seen <= 1'b0;
            done_seen <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            done <= 1'b0;
        end else begin
            ack_seen <= ack_s;
            rx_seen <= rxt_s;
            done_seen <= done_s;
            rx_valid <= rx_keep;
            rx_data <= rx_keep ? l_rx_word : rx_data;
            done <= done_ev && busy && !bus_off;    // [RULE_13]
        end
    end

    // ****************************************************************
    // Link side decode
    // ****************************************************************
    wire l_need_tx = l_mode != sms_pkg::MODE_READ;
    wire l_pend = l_req_s != l_tx_seen;
    wire l_start_ev = l_start_s != l_start_seen;
    wire l_in_shift = l_st == sms_pkg::SMS_L_SHIFT;
    wire l_go = l_en_s && l_st == sms_pkg::SMS_L_IDLE && l_start_ev;
    wire l_load = l_en_s && l_st == sms_pkg::SMS_L_LOAD && (!l_need_tx || l_pend);
    wire l_tick = l_en_s && l_in_shift && l_hcnt == 8'h00;
    wire l_last = l_edge == {l_bits, 1'b1};    // [RULE_04]
    wire l_word_end = l_tick && l_last;
    wire l_final = l_word_end && l_left == 8'h01;
    wire l_samp_e = l_edge[0] == l_cpha;    // [RULE_03]
    wire l_drive_e = l_edge[0] != l_cpha && !(!l_cpha && l_last);
    wire [2:0] l_drive_k = l_cpha ? l_edge[3:1] : l_edge[3:1] + 3'h1;
    wire [2:0] l_samp_pos = l_lsb ? l_edge[3:1] : l_bits - l_edge[3:1];    // [RULE_05]
    wire [2:0] l_drive_pos = l_lsb ? l_drive_k : l_bits - l_drive_k;
    wire [2:0] l_first_pos = l_lsb ? 3'h0 : l_bits;
    wire [7:0] l_load_w = l_need_tx ? tx_hold : l_fill;    // [RULE_07]
    wire l_first_bit = l_load_w[l_first_pos];
    wire [7:0] l_mask = 8'h01 << l_samp_pos;
    wire [7:0] l_rx_new = l_samp_e ? ((l_rxw & ~l_mask) | (l_miso_s ? l_mask : 8'h00)) : l_rxw;
    wire l_deliver = l_word_end && l_mode != sms_pkg::MODE_WRITE;    // [RULE_08]
    wire l_ack_now = (!l_en_s && l_pend) || (l_load && l_need_tx);

    // ****************************************************************
    // Link side registers
    // ****************************************************************
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_st <= sms_pkg::SMS_L_IDLE;
        end else if (!l_en_s) begin
            l_st <= sms_pkg::SMS_L_IDLE;    // [RULE_11]
        end else begin
            unique case (l_st)
                sms_pkg::SMS_L_IDLE: l_st <= l_go ? sms_pkg::SMS_L_LOAD : sms_pkg::SMS_L_IDLE;
                sms_pkg::SMS_L_LOAD: l_st <= l_load ? sms_pkg::SMS_L_SHIFT : sms_pkg::SMS_L_LOAD;
                sms_pkg::SMS_L_SHIFT: begin
                    if (l_word_end) begin
                        l_st <= l_final ? sms_pkg::SMS_L_IDLE : sms_pkg::SMS_L_LOAD; // [RULE_13]
                    end
                end
                default: l_st <= sms_pkg::SMS_L_IDLE;
            endcase
        end
    end

    // Only this block drives the clock pin; it rests at polarity outside a transfer.
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            spi_sck <= sms_pkg::RST_CPOL;
            spi_mosi <= 1'b0;
        end else begin
            if (!l_en_s || l_st == sms_pkg::SMS_L_IDLE) begin
                spi_sck <= l_cpol_s;    // [RULE_01] [RULE_02]
            end else if (l_tick) begin
                spi_sck <= ~spi_sck;
            end
            if (!l_en_s) begin
                spi_mosi <= 1'b0;
            end else if (l_load && !l_cpha) begin
                spi_mosi <= l_first_bit;
            end else if (l_tick && l_drive_e) begin
                spi_mosi <= l_word[l_drive_pos];    // [RULE_05]
            end
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_hcnt <= 8'h00;
            l_edge <= 4'h0;
            l_left <= 8'h00;
        end else begin
            if (l_load || l_tick) begin
                l_hcnt <= l_div - 8'h01;    // [RULE_06]
            end else if (l_in_shift) begin
                l_hcnt <= l_hcnt - 8'h01;
            end
            l_edge <= l_load ? 4'h0 : l_tick ? l_edge + 4'h1 : l_edge;
            l_left <= l_go ? count_q : l_word_end ? l_left - 8'h01 : l_left;    // [RULE_09]
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_word <= 8'h00;
            l_rxw <= 8'h00;
            l_rx_word <= 8'h00;
        end else begin
            l_word <= l_load ? l_load_w : l_word;
            l_rxw <= l_load ? 8'h00 : l_tick ? l_rx_new : l_rxw;    // [RULE_03]
            l_rx_word <= l_deliver ? l_rx_new : l_rx_word;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_start_seen <= 1'b0;
            l_tx_seen <= 1'b0;
            l_ack <= 1'b0;
            l_rx_tgl <= 1'b0;
            l_done_tgl <= 1'b0;
        end else begin
            l_start_seen <= l_start_s;
            l_tx_seen <= l_ack_now ? l_req_s : l_tx_seen;
            l_ack <= l_ack_now ? ~l_ack : l_ack;
            l_rx_tgl <= l_deliver ? ~l_rx_tgl : l_rx_tgl;    // [RULE_07] [RULE_09]
            l_done_tgl <= l_final ? ~l_done_tgl : l_done_tgl;
        end
    end

    // Settings are held still on the system side while busy, so one capture is safe.
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_cpha <= sms_pkg::RST_CPHA;
            l_bits <= sms_pkg::RST_BITS;
            l_lsb <= sms_pkg::RST_LSB_FIRST;
            l_div <= sms_pkg::DEFAULT_HALF_DIV;
            l_fill <= sms_pkg::RST_FILL;
            l_mode <= sms_pkg::MODE_NONE;
        end else if (l_go) begin
            l_cpha <= cur_cpha;
            l_bits <= cur_bits;
            l_lsb <= cur_lsb;
            l_div <= cur_div;
            l_fill <= cur_fill;
            l_mode <= mode;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_ready_mode;
        @(posedge clk) disable iff (sys_rst)
        tx_ready |-> busy && mode != sms_pkg::MODE_READ && !tx_full;
    endproperty
    a_ready_mode: assert property (p_ready_mode) else $error("tx_ready out of turn"); // [RULE_07]

    property p_write_no_rx;
        @(posedge clk) disable iff (sys_rst)
        rx_valid |-> mode != sms_pkg::MODE_WRITE;
    endproperty
    a_write_no_rx: assert property (p_write_no_rx) else $error("rx in write mode"); // [RULE_08]

    property p_off_stops;
        @(posedge clk) disable iff (sys_rst)
        bus_off |=> !busy && !cfg_active && !tx_ready ##[1:40] !l_en_s;
    endproperty
    a_off_stops: assert property (p_off_stops) else $error("bus active after off"); // [RULE_11]

    property p_cfg_persist;
        @(posedge clk) disable iff (sys_rst)
        !cfg_load |=> $stable(cur_div) && $stable(cur_bits) && $stable(cur_fill);
    endproperty
    a_cfg_persist: assert property (p_cfg_persist) else $error("settings drifted"); // [RULE_12]

    property p_duplex_count;
        @(posedge clk) disable iff (sys_rst)
        cmd_go && cmd_mode == sms_pkg::MODE_DUPLEX |=> busy && tx_left == count_q;
    endproperty
    a_duplex_count: assert property (p_duplex_count) else $error("duplex count off"); // [RULE_09]

    property p_done_end;
        @(posedge clk) disable iff (sys_rst)
        done |-> !busy && $past(busy);
    endproperty
    a_done_end: assert property (p_done_end) else $error("done without ending busy"); // [RULE_13]

    property p_idle_level;
        @(posedge link_clk) disable iff (link_rst)
        l_en_s && l_st == sms_pkg::SMS_L_IDLE |=> spi_sck == $past(l_cpol_s);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not idle"); // [RULE_02]

    property p_master;
        @(posedge link_clk) disable iff (link_rst)
        $changed(spi_sck) |-> $past(l_tick) || !$past(l_in_shift);
    endproperty
    a_master: assert property (p_master) else $error("clock moved outside an edge"); // [RULE_01]

    property p_half;
        @(posedge link_clk) disable iff (link_rst)
        l_en_s && l_in_shift && l_hcnt != 8'h00 |=> $stable(spi_sck);
    endproperty
    a_half: assert property (p_half) else $error("clock edge before half period"); // [RULE_06]

    property p_sample;
        @(posedge link_clk) disable iff (link_rst)
        l_tick && !l_samp_e |=> l_rxw == $past(l_rxw);
    endproperty
    a_sample: assert property (p_sample) else $error("sample on wrong edge"); // [RULE_03]

    property p_order;
        @(posedge link_clk) disable iff (link_rst)
        l_load && !l_cpha |=> spi_mosi == $past(l_first_bit);
    endproperty
    a_order: assert property (p_order) else $error("first bit wrong"); // [RULE_05]

    property p_fill;
        @(posedge link_clk) disable iff (link_rst)
        l_load && l_mode == sms_pkg::MODE_READ |=> l_word == $past(l_fill);
    endproperty
    a_fill: assert property (p_fill) else $error("fill byte not sent"); // [RULE_07]

    property p_word_end;
        @(posedge link_clk) disable iff (link_rst)
        l_word_end |=> spi_sck == $past(l_cpol_s) && l_st != sms_pkg::SMS_L_SHIFT;
    endproperty
    a_word_end: assert property (p_word_end) else $error("clock not idle after word"); // [RULE_13]

    property p_disabled;
        @(posedge link_clk) disable iff (link_rst)
        !l_en_s |=> l_st == sms_pkg::SMS_L_IDLE && !spi_mosi;
    endproperty
    a_disabled: assert property (p_disabled) else $error("shifting while disabled"); // [RULE_11]

    c_read_done: cover property (@(posedge clk) disable iff (sys_rst)
        done && mode == sms_pkg::MODE_READ);
    c_write_done: cover property (@(posedge clk) disable iff (sys_rst)
        done && mode == sms_pkg::MODE_WRITE);
    c_duplex_done: cover property (@(posedge clk) disable iff (sys_rst)
        done && mode == sms_pkg::MODE_DUPLEX);
    c_abort: cover property (@(posedge clk) disable iff (sys_rst) busy && bus_off);

endmodule : sms_top

// ==== core/sms_pkg.sv ====
// Shared constants and types for the serial peripheral master shifter.
package sms_pkg;

    // ****************************************************************
    // Rates and timing
    // ****************************************************************
    localparam int LINK_CLK_HZ = 20833333;
    localparam int DEFAULT_BAUD_HZ = 1000000;
    localparam logic [7:0] DEFAULT_HALF_DIV =
        8'((LINK_CLK_HZ + 2 * DEFAULT_BAUD_HZ - 1) / (2 * DEFAULT_BAUD_HZ));
    localparam logic [7:0] MIN_HALF_DIV = 8'h03;

    // ****************************************************************
    // Transfer modes
    // ****************************************************************
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_READ = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_DUPLEX = 2'h3;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic RST_CPOL = 1'b0;
    localparam logic RST_CPHA = 1'b0;
    localparam logic [2:0] RST_BITS = 3'h7;
    localparam logic RST_LSB_FIRST = 1'b0;
    localparam logic [7:0] RST_FILL = 8'h00;

    // ****************************************************************
    // Link side states
    // ****************************************************************
    typedef enum logic [2:0] {
        SMS_L_IDLE = 3'h1,
        SMS_L_LOAD = 3'h2,
        SMS_L_SHIFT = 3'h4
    } sms_lstate_t;

endpackage : sms_pkg

// ==== core/sms_sync.sv ====
// Two flip-flop level synchroniser.
`timescale 1ns/100ps
module sms_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sms_sync

// ==== core/sms_rst_sync.sv ====
// Reset synchroniser: asserts at once, releases on the local clock.
`timescale 1ns/100ps
module sms_rst_sync (
    // Local clock
    input wire logic clk,
    // Reset in and out
    input wire logic rst_in,
    output logic rst_out
);
    logic meta;

    always_ff @(posedge clk or posedge rst_in) begin
        if (rst_in) begin
            meta <= 1'b1;
            rst_out <= 1'b1;
        end else begin
            meta <= 1'b0;
            rst_out <= meta;
        end
    end
endmodule : sms_rst_sync

// ==== bench/sms_slave_model.sv ====
// Serial slave model: shifts a fixed byte out and collects the bits it hears.
`timescale 1ns/100ps
module sms_slave_model (
    // Select and settings
    input wire logic sel_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic [7:0] reply,
    // Serial pins
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic [7:0] heard
);
    int ob = 0;
    task automatic drive;
        spi_miso = reply[lsb_first ? ob : 7 - ob];
        ob = (ob + 1) % 8;
    endtask : drive
    initial spi_miso = 1'b0;
    initial heard = 8'h00;
    // Select is a separate pin driven by the bench.
    always @(negedge sel_n) begin
        ob = 0;
        if (!cpha) drive();
    end
    // A released line must not keep showing the last bit.
    always @(posedge sel_n) spi_miso = ~spi_miso;
    always @(spi_sck) begin
        if (!sel_n && ((spi_sck != cpol) == !cpha)) begin
            heard = lsb_first ? {spi_mosi, heard[7:1]} : {heard[6:0], spi_mosi};
        end else if (!sel_n) begin
            drive();
        end
    end
endmodule : sms_slave_model

// ==== bench/sms_top_tb_top.sv ====
// Self-checking testbench for the serial master shifter.
`timescale 1ns/100ps
module sms_top_tb_top;
    logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, cfg_load = 1'b0;
    logic cfg_cpol = 1'b0, cfg_cpha = 1'b0, cfg_lsb_first = 1'b0, bus_off = 1'b0;
    logic cmd_valid = 1'b0, tx_valid = 1'b0, sel_n = 1'b1, spi_miso;
    logic s_cpol = 1'b0, s_cpha = 1'b0, s_lsb = 1'b0;
    logic [2:0] cfg_bits = 3'h7;
    logic [1:0] cmd_mode = 2'h0;
    logic [7:0] cfg_half_div = 8'h06, cfg_fill = 8'h00, cmd_count = 8'h00, tx_data = 8'h00;
    logic [7:0] reply = 8'h00, heard, rx_data, last;
    logic cfg_active, busy, done, tx_ready, rx_valid, spi_sck, spi_mosi;
    int errors = 0, n_compared = 0, nrx, ndone;
    initial forever #2.5 clk = ~clk;
    // The odd start offset keeps the two clocks out of step.
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    sms_top u_sms_top (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .cfg_load(cfg_load), .cfg_cpol(cfg_cpol), .cfg_cpha(cfg_cpha), .cfg_bits(cfg_bits),
        .cfg_lsb_first(cfg_lsb_first), .cfg_half_div(cfg_half_div), .cfg_fill(cfg_fill),
        .bus_off(bus_off), .cfg_active(cfg_active), .cmd_valid(cmd_valid),
        .cmd_mode(cmd_mode), .cmd_count(cmd_count), .busy(busy), .done(done),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    sms_slave_model u_sms_slave_model (.sel_n(sel_n), .cpol(s_cpol), .cpha(s_cpha),
        .lsb_first(s_lsb), .reply(reply), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .heard(heard));
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic results;
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic setup(input logic p, h, l, input logic [7:0] div);
        @(negedge clk);
        {cfg_cpol, cfg_cpha, cfg_lsb_first, cfg_half_div} = {p, h, l, div};
        {s_cpol, s_cpha, s_lsb} = {p, h, l};
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
        chk("active", 1, cfg_active);
        repeat (200) @(negedge clk);
    endtask : setup
    task automatic xfer(input logic [1:0] m, input logic [7:0] n, d);
        int t, k;
        @(negedge clk);
        sel_n = 1'b0;
        {cmd_valid, cmd_mode, cmd_count} = {1'b1, m, n};
        @(negedge clk);
        cmd_valid = 1'b0;
        {nrx, ndone, t, k} = '0;
        while (ndone == 0 && busy && t < 12000) begin
            @(negedge clk);
            t++;
            if (tx_valid) k++;
            tx_valid = tx_ready && k < n;
            tx_data = d + 8'(k);
            if (rx_valid) nrx++;
            if (rx_valid) last = rx_data;
            if (done) ndone++;
        end
        chk("busy", 0, busy);
        repeat (30) @(negedge link_clk);
        chk("sck idle", s_cpol, spi_sck);
        @(negedge clk);
        sel_n = 1'b1;
    endtask : xfer
    task automatic t_rate;
        realtime t0;
        setup(0, 0, 0, 8'h00);
        fork
            xfer(sms_pkg::MODE_WRITE, 8'h01, 8'h77);
            begin
                @(posedge spi_sck);
                t0 = $realtime;
                @(negedge spi_sck);
                chk("half", sms_pkg::DEFAULT_HALF_DIV * 48, int'($realtime - t0));
            end
        join
        chk("heard", 8'h77, heard);
    endtask : t_rate
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            setup(i[1], i[0], i[0], 8'h06);
            reply = 8'h3C ^ 8'(i);
            xfer(sms_pkg::MODE_DUPLEX, 8'h02, 8'hA0 + 8'(i));
            chk("duplex rx", 2, nrx);
            chk("rx word", reply, last);
            chk("tx word", 8'hA1 + 8'(i), heard);
            chk("done", 1, ndone);
        end
    endtask : t_modes
    task automatic t_rw;
        cfg_fill = 8'h5A;
        setup(0, 0, 0, 8'h06);
        reply = 8'hC3;
        xfer(sms_pkg::MODE_READ, 8'h03, 8'h00);
        chk("read rx", 3, nrx);
        chk("read word", 8'hC3, last);
        chk("fill", 8'h5A, heard);
        cfg_lsb_first = 1'b1;
        xfer(sms_pkg::MODE_WRITE, 8'h02, 8'h91);
        chk("write rx", 0, nrx);
        chk("write word", 8'h92, heard);
        cfg_bits = 3'h3;
        setup(0, 0, 0, 8'h06);
        xfer(sms_pkg::MODE_READ, 8'h01, 8'h00);
        chk("narrow word", 8'h0C, last);
        chk("narrow fill", 4'hA, heard[3:0]);
        cfg_bits = 3'h7;
    endtask : t_rw
    task automatic t_abort;
        setup(1, 0, 0, 8'h06);
        fork
            xfer(sms_pkg::MODE_READ, 8'h05, 8'h00);
            begin
                repeat (400) @(negedge clk);
                bus_off = 1'b1;
                @(negedge clk);
                bus_off = 1'b0;
                @(negedge clk);
                chk("off", 0, cfg_active);
            end
        join
        chk("abort done", 0, ndone);
        xfer(sms_pkg::MODE_READ, 8'h01, 8'h00);
        chk("no start", 0, ndone + nrx);
    endtask : t_abort
    initial begin
        repeat (5) @(negedge link_clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk("reset sck", 0, spi_sck);
        chk("reset active", 0, cfg_active);
        t_rate;
        t_modes;
        t_rw;
        t_abort;
        results;
    end
    initial begin
        #400us;
        errors++;
        results;
    end
endmodule : sms_top_tb_top
